// ===== lgm_pkg.sv
package lgm_pkg;

    // ****************************************
    // command codes
    // ****************************************
    localparam logic [7:0] CMD_WR_SP = 8'h0F;
    localparam logic [7:0] CMD_RD_SP = 8'hAA;
    localparam logic [7:0] CMD_COPY = 8'h55;
    localparam logic [7:0] CMD_RD_MEM = 8'hF0;
    localparam logic [7:0] CMD_RD_CRC = 8'hA5;
    localparam logic [7:0] CMD_CLEAR = 8'h3C;
    localparam logic [7:0] CMD_CONVERT = 8'h44;

    // ****************************************
    // memory map and field positions
    // ****************************************
    localparam logic [15:0] MISSION_REG_FIRST = 16'h0200;
    localparam logic [15:0] MISSION_REG_LAST = 16'h0213;
    localparam logic [15:0] SAMPLE_RATE_ADDR = 16'h020D;
    localparam logic [15:0] CONTROL_ADDR = 16'h020E;
    localparam logic [15:0] STATUS_ADDR = 16'h0214;
    localparam logic [15:0] MEM_LAST_ADDR = 16'h17FF;
    localparam int RUN_BIT = 5;
    localparam int CLR_EN_BIT = 6;
    localparam logic [4:0] SP_LAST_OFF = 5'h1F;

    // ****************************************
    // crc constants and fixed byte patterns
    // ****************************************
    localparam logic [15:0] CRC_POLY = 16'hA001;
    localparam logic [15:0] CRC_INIT = 16'h0000;
    localparam logic [7:0] ALT_PATTERN = 8'h55;
    localparam logic [7:0] ONES_BYTE = 8'hFF;
    localparam logic [7:0] ZERO_BYTE = 8'h00;

    // ****************************************
    // timing
    // ****************************************
    localparam int CLK_PERIOD_NS = 40;
    localparam int COPY_BYTE_NS = 2000;
    localparam int CLEAR_US = 500;
    localparam logic [15:0] COPY_BYTE_CYC =
        16'((COPY_BYTE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam int CLEAR_CYC = (CLEAR_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ****************************************
    // transmit buffer and reset values
    // ****************************************
    localparam int TX_FIFO_WIDTH = 8;
    localparam int TX_FIFO_DEPTH = 8;
    localparam logic MEM_CLR_RST = 1'b0;
    localparam logic [15:0] DELAY_RST = 16'h0000;

endpackage

// ===== lgm_fifo.sv
`timescale 1ns/100ps
module lgm_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    input wire logic flush,
    // filling side
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    // draining side
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready
);
    // depth must be a power of two: pointers wrap by overflow
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [CW-1:0] cnt;
    } lgm_fifo_regs_t;

    lgm_fifo_regs_t q;
    lgm_fifo_regs_t n;
    logic push;
    logic pop;

    assign in_ready = (q.cnt != FULL_CNT);
    assign out_valid = (q.cnt != {CW{1'b0}});
    assign out_data = q.mem[q.rd];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb begin
        n = q;
        if (push) begin
            n.mem[q.wr] = in_data;
            n.wr = q.wr + AW'(1);
        end
        if (pop) begin
            n.rd = q.rd + AW'(1);
        end
        if (push && !pop) begin
            n.cnt = q.cnt + CW'(1);
        end else if (pop && !push) begin
            n.cnt = q.cnt - CW'(1);
        end
        if (flush) begin
            n.wr = '0;
            n.rd = '0;
            n.cnt = '0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end
endmodule

// ===== lgm_cmd_top.sv
`timescale 1ns/100ps
module lgm_cmd_top
    import lgm_pkg::*;
#(
    parameter int CLEAR_CYCLES = lgm_pkg::CLEAR_CYC
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // byte link from the bit layer
    input wire logic [7:0] rx_data,
    input wire logic rx_valid,
    input wire logic rx_partial,
    input wire logic bus_reset,
    // byte link to the bit layer
    output logic [7:0] tx_data,
    output logic tx_valid,
    input wire logic tx_ready,
    // memory port
    output logic mem_rd,
    output logic mem_we,
    output logic [15:0] mem_addr,
    output logic [7:0] mem_wdata,
    input wire logic [7:0] mem_rdata,
    input wire logic mem_rvalid,
    // mission control
    input wire logic minute_tick,
    input wire logic sample_in_progress,
    input wire logic mission_enable_low,
    input wire logic [15:0] start_delay,
    // status
    output logic copy_accepted_flag,
    output logic clear_enable_bit,
    output logic memory_cleared_bit,
    output logic mission_in_progress,
    output logic clear_active,
    output logic convert_req,
    output logic timestamp_capture,
    output logic logging_active
);
    import lgm_pkg::*;

    // ****************************************
    // state
    // ****************************************
    typedef enum logic [3:0] {
        ST_IDLE = 4'h0, ST_ADR_LO = 4'h1, ST_ADR_HI = 4'h2, ST_WS = 4'h3,
        ST_RS_HDR = 4'h4, ST_RS_DATA = 4'h5, ST_CRC_LO = 4'h6, ST_CRC_HI = 4'h7,
        ST_ONES = 4'h8, ST_CP_AUTH = 4'h9, ST_CP_RUN = 4'hA, ST_CP_DONE = 4'hB,
        ST_RM_REQ = 4'hC, ST_RM_WAIT = 4'hD, ST_CLR = 4'hE, ST_HOLD = 4'hF
    } lgm_state_t;

    typedef enum logic [1:0] {
        MS_IDLE = 2'b00, MS_DELAY = 2'b01, MS_WAIT = 2'b10, MS_LOG = 2'b11
    } lgm_msn_t;

    typedef struct packed {
        lgm_state_t st;
        lgm_msn_t msn;
        logic [7:0] cmd;
        logic [15:0] ta;
        logic [4:0] es_off;
        logic part;
        logic acc;
        logic [31:0][7:0] sp;
        logic [4:0] idx;
        logic [15:0] crc;
        logic [15:0] addr;
        logic [15:0] cnt;
        logic crc_next;
        logic clr_en;
        logic mem_clr;
        logic run;
        logic [15:0] delay;
        logic push_v;
        logic [7:0] push_d;
        logic mem_rd;
        logic mem_we;
        logic [15:0] mem_addr;
        logic [7:0] mem_wdata;
        logic clr_act;
        logic convert_req;
        logic ts_cap;
        logic log_act;
    } lgm_regs_t;

    lgm_regs_t q;
    lgm_regs_t n;
    logic fifo_in_ready;
    logic flush;

    localparam logic [15:0] CLEAR_LAST = 16'(CLEAR_CYCLES - 1);

    function automatic logic [15:0] crc16_byte(input logic [15:0] c, input logic [7:0] d);
        logic [15:0] r;
        logic fb;
        r = c;
        for (int i = 0; i < 8; i++) begin
            fb = r[0] ^ d[i];
            r = {1'b0, r[15:1]};
            if (fb) begin
                r = r ^ CRC_POLY;
            end
        end
        return r;
    endfunction

    // ****************************************
    // command interpreter
    // ****************************************
    always_comb begin
        logic slot_free;
        logic rd_emit;
        logic [7:0] rd_byte;
        logic [7:0] es_byte;
        logic [7:0] auth_exp;
        logic [7:0] wbyte;
        slot_free = !q.push_v || fifo_in_ready;
        rd_emit = 1'b0;
        rd_byte = ZERO_BYTE;
        es_byte = {q.acc, 1'b0, q.part, q.es_off};
        auth_exp = (q.cnt == 16'h0000) ? q.ta[7:0] :
                   (q.cnt == 16'h0001) ? q.ta[15:8] : es_byte;
        wbyte = q.sp[q.idx];
        flush = 1'b0;
        n = q;
        if (slot_free) begin
            n.push_v = 1'b0;
        end
        n.mem_rd = 1'b0;
        n.mem_we = 1'b0;
        n.convert_req = 1'b0;
        n.ts_cap = 1'b0;
        // mission sequencer runs on minute boundaries
        unique case (q.msn)
            MS_IDLE: begin
            end
            MS_DELAY: if (minute_tick) begin
                n.delay = q.delay - 16'h0001;
                if (q.delay == 16'h0001) begin
                    n.msn = MS_WAIT;
                end
            end
            MS_WAIT: if (minute_tick) begin
                n.ts_cap = 1'b1;
                n.msn = MS_LOG;
            end
            MS_LOG: begin
            end
        endcase
        unique case (q.st)
            ST_IDLE: if (rx_valid) begin
                n.cmd = rx_data;
                n.crc = crc16_byte(CRC_INIT, rx_data);
                n.cnt = 16'h0000;
                n.st = ST_HOLD;
                if (rx_data != CMD_CLEAR) begin
                    n.clr_en = 1'b0;
                end
                case (rx_data)
                    CMD_WR_SP: begin
                        n.acc = 1'b0;
                        n.part = 1'b0;
                        n.st = ST_ADR_LO;
                    end
                    CMD_RD_MEM, CMD_RD_CRC: n.st = ST_ADR_LO;
                    CMD_RD_SP: n.st = ST_RS_HDR;
                    CMD_COPY: n.st = ST_CP_AUTH;
                    CMD_CLEAR: if (q.clr_en) begin
                        n.st = ST_CLR;
                        n.clr_act = 1'b1;
                    end
                    CMD_CONVERT: n.convert_req = !q.run;
                    default: n.st = ST_HOLD;
                endcase
            end
            ST_ADR_LO: if (rx_valid) begin
                n.ta[7:0] = rx_data;
                n.crc = crc16_byte(q.crc, rx_data);
                n.st = ST_ADR_HI;
            end
            ST_ADR_HI: if (rx_valid) begin
                // status byte untouched by reads
                n.ta[15:8] = rx_data;
                n.crc = crc16_byte(q.crc, rx_data);
                n.addr = {rx_data, q.ta[7:0]};
                n.idx = q.ta[4:0];
                n.st = (q.cmd == CMD_WR_SP) ? ST_WS : ST_RM_REQ;
            end
            ST_WS: begin
                if (rx_partial) begin
                    n.part = 1'b1;
                end
                if (rx_valid) begin
                    n.sp[q.idx] = rx_data;
                    n.es_off = q.idx;
                    n.idx = q.idx + 5'h01;
                    if (q.idx == SP_LAST_OFF) begin
                        n.st = ST_HOLD;
                    end
                end
            end
            ST_RS_HDR: if (slot_free) begin
                n.push_v = 1'b1;
                n.push_d = auth_exp;
                n.crc = crc16_byte(q.crc, auth_exp);
                n.cnt = q.cnt + 16'h0001;
                if (q.cnt == 16'h0002) begin
                    n.idx = q.ta[4:0];
                    n.st = ST_RS_DATA;
                end
            end
            ST_RS_DATA: if (slot_free) begin
                n.push_v = 1'b1;
                n.push_d = wbyte;
                n.crc = crc16_byte(q.crc, wbyte);
                n.idx = q.idx + 5'h01;
                if (q.idx == SP_LAST_OFF) begin
                    n.crc_next = 1'b0;
                    n.st = ST_CRC_LO;
                end
            end
            ST_CRC_LO: if (slot_free) begin
                n.push_v = 1'b1;
                n.push_d = ~q.crc[7:0];
                n.st = ST_CRC_HI;
            end
            ST_CRC_HI: if (slot_free) begin
                n.push_v = 1'b1;
                n.push_d = ~q.crc[15:8];
                n.crc = CRC_INIT;
                n.st = q.crc_next ? ST_RM_REQ : ST_ONES;
            end
            ST_ONES: if (slot_free) begin
                n.push_v = 1'b1;
                n.push_d = ONES_BYTE;
            end
            ST_CP_AUTH: if (rx_valid) begin
                if (rx_data != auth_exp) begin
                    n.st = ST_HOLD;
                end else if (q.cnt == 16'h0002) begin
                    n.acc = 1'b1;
                    n.idx = q.ta[4:0];
                    n.addr = q.ta;
                    n.cnt = 16'h0000;
                    n.st = ST_CP_RUN;
                end else begin
                    n.cnt = q.cnt + 16'h0001;
                end
            end
            ST_CP_RUN: begin
                if (q.cnt == 16'h0000) begin
                    n.mem_we = 1'b1;
                    n.mem_addr = q.addr;
                    n.mem_wdata = wbyte;
                    if (q.run && q.addr >= MISSION_REG_FIRST && q.addr <= MISSION_REG_LAST) begin
                        n.run = 1'b0;
                        n.msn = MS_IDLE;
                    end
                    if (q.addr == STATUS_ADDR && !wbyte[RUN_BIT]) begin
                        n.run = 1'b0;
                        n.msn = MS_IDLE;
                    end
                    if (q.addr == CONTROL_ADDR) begin
                        n.clr_en = wbyte[CLR_EN_BIT];
                    end
                    if (q.addr == SAMPLE_RATE_ADDR && wbyte != ZERO_BYTE && !q.run
                        && q.mem_clr && !mission_enable_low) begin
                        n.run = 1'b1;
                        n.mem_clr = 1'b0;
                        n.delay = start_delay;
                        n.msn = (start_delay == 16'h0000) ? MS_WAIT : MS_DELAY;
                    end
                end
                n.cnt = q.cnt + 16'h0001;
                if (q.cnt == COPY_BYTE_CYC - 16'h0001) begin
                    n.cnt = 16'h0000;
                    n.idx = q.idx + 5'h01;
                    n.addr = q.addr + 16'h0001;
                    if (q.idx == q.es_off) begin
                        n.st = ST_CP_DONE;
                    end
                end
            end
            ST_CP_DONE: if (slot_free) begin
                n.push_v = 1'b1;
                n.push_d = ALT_PATTERN;
            end
            ST_RM_REQ: if (slot_free) begin
                if (q.addr > MEM_LAST_ADDR) begin
                    rd_emit = 1'b1;
                end else if (!sample_in_progress) begin
                    n.mem_rd = 1'b1;
                    n.mem_addr = q.addr;
                    n.st = ST_RM_WAIT;
                end
            end
            ST_RM_WAIT: if (mem_rvalid) begin
                rd_emit = 1'b1;
                rd_byte = mem_rdata;
            end
            ST_CLR: begin
                n.cnt = q.cnt + 16'h0001;
                if (q.cnt == CLEAR_LAST) begin
                    n.clr_act = 1'b0;
                    n.mem_clr = 1'b1;
                    n.clr_en = 1'b0;
                    n.st = ST_HOLD;
                end
            end
            ST_HOLD: begin
            end
        endcase
        // shared tail of both memory reads
        if (rd_emit) begin
            n.push_v = 1'b1;
            n.push_d = rd_byte;
            n.crc = crc16_byte(q.crc, rd_byte);
            n.addr = q.addr + 16'h0001;
            n.st = ST_RM_REQ;
            if (q.cmd == CMD_RD_CRC && q.addr[4:0] == SP_LAST_OFF) begin
                n.crc_next = 1'b1;
                n.st = ST_CRC_LO;
            end
        end
        // copy and clear must finish; a reset mid-copy would leave a torn page
        if (bus_reset && q.st != ST_CP_RUN && q.st != ST_CLR) begin
            n.st = ST_IDLE;
            n.push_v = 1'b0;
            flush = 1'b1;
        end
        n.log_act = (n.msn == MS_LOG);
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            q <= '0;
            q.mem_clr <= MEM_CLR_RST;
            q.delay <= DELAY_RST;
        end else begin
            q <= n;
        end
    end

    // ****************************************
    // transmit buffer
    // ****************************************
    lgm_fifo #(
        .WIDTH(TX_FIFO_WIDTH),
        .DEPTH(TX_FIFO_DEPTH)
    ) u_tx_fifo (
        .core_clk(core_clk),
        .rst(rst),
        .flush(flush),
        .in_valid(q.push_v),
        .in_data(q.push_d),
        .in_ready(fifo_in_ready),
        .out_valid(tx_valid),
        .out_data(tx_data),
        .out_ready(tx_ready)
    );

    assign mem_rd = q.mem_rd;
    assign mem_we = q.mem_we;
    assign mem_addr = q.mem_addr;
    assign mem_wdata = q.mem_wdata;
    assign copy_accepted_flag = q.acc;
    assign clear_enable_bit = q.clr_en;
    assign memory_cleared_bit = q.mem_clr;
    assign mission_in_progress = q.run;
    assign clear_active = q.clr_act;
    assign convert_req = q.convert_req;
    assign timestamp_capture = q.ts_cap;
    assign logging_active = q.log_act;

    // ****************************************
    // assertions
    // ****************************************
    logic in_copy;
    logic auth_last_ok;
    logic wr_cmd;
    assign in_copy = (q.st == ST_CP_RUN);
    assign auth_last_ok = (q.st == ST_CP_AUTH) && rx_valid && (q.cnt == 16'h0002)
                          && (rx_data == {q.acc, 1'b0, q.part, q.es_off});
    assign wr_cmd = (q.st == ST_IDLE) && rx_valid && (rx_data == CMD_WR_SP);

    property p_acc_set;
        @(posedge core_clk) disable iff (rst) auth_last_ok |=> copy_accepted_flag ##1 in_copy;
    endproperty
    a_acc_set: assert property (p_acc_set) else $error("copy flag not set on match");

    property p_reset_ignored;
        @(posedge core_clk) disable iff (rst) in_copy && bus_reset |=> (q.st != ST_IDLE);
    endproperty
    a_reset_ignored: assert property (p_reset_ignored) else $error("reset ended copy");

    property p_acc_clear;
        @(posedge core_clk) disable iff (rst) $fell(copy_accepted_flag) |-> $past(wr_cmd);
    endproperty
    a_acc_clear: assert property (p_acc_clear) else $error("copy flag cleared wrongly");

    property p_clear_done;
        @(posedge core_clk) disable iff (rst)
            $fell(clear_active) |-> memory_cleared_bit && !clear_enable_bit;
    endproperty
    a_clear_done: assert property (p_clear_done) else $error("clear end flags wrong");

    property p_clear_len;
        @(posedge core_clk) disable iff (rst) $rose(clear_active) |-> clear_active [*8];
    endproperty
    a_clear_len: assert property (p_clear_len) else $error("clear ended too early");

    property p_convert_gate;
        @(posedge core_clk) disable iff (rst) convert_req |-> !mission_in_progress;
    endproperty
    a_convert_gate: assert property (p_convert_gate) else $error("convert during mission");

    property p_mip_start;
        @(posedge core_clk) disable iff (rst)
            $rose(mission_in_progress) |-> $fell(memory_cleared_bit) && $past(mem_we, 1) == 1'b0;
    endproperty
    a_mip_start: assert property (p_mip_start) else $error("mission start flags wrong");

    property p_sample_prio;
        @(posedge core_clk) disable iff (rst) mem_rd |-> !$past(sample_in_progress);
    endproperty
    a_sample_prio: assert property (p_sample_prio) else $error("read during sampling");

    property p_ts;
        @(posedge core_clk) disable iff (rst)
            timestamp_capture |-> logging_active && mission_in_progress;
    endproperty
    a_ts: assert property (p_ts) else $error("timestamp outside mission");

    c_copy: cover property (@(posedge core_clk) disable iff (rst) $rose(copy_accepted_flag));
    c_clear: cover property (@(posedge core_clk) disable iff (rst) $rose(memory_cleared_bit));
    c_mission: cover property (@(posedge core_clk) disable iff (rst) timestamp_capture);
    c_page_crc: cover property (@(posedge core_clk) disable iff (rst)
        q.st == ST_CRC_HI && q.crc_next);
endmodule

// ===== lgm_mem_model.sv
`timescale 1ns/100ps
module lgm_mem_model (
    // clock
    input wire logic core_clk,
    // answer speed, cycles added before each read answer
    input wire logic [1:0] slow,
    // memory port
    input wire logic mem_rd,
    input wire logic mem_we,
    input wire logic [15:0] mem_addr,
    input wire logic [7:0] mem_wdata,
    output logic [7:0] mem_rdata,
    output logic mem_rvalid
);
    logic [7:0] mem [0:8191];
    logic busy = 1'b0;
    logic [15:0] a = 16'h0000;
    logic [1:0] n = 2'h0;
    initial begin
        for (int i = 0; i < 8192; i++) mem[i] = i[7:0];
        mem_rdata = 8'h5A;
        mem_rvalid = 1'b0;
    end
    always @(posedge core_clk) begin
        mem_rvalid <= 1'b0;
        // data is only worth taking with the strobe, so it keeps changing
        mem_rdata <= ~mem_rdata;
        if (mem_we) mem[mem_addr[12:0]] <= mem_wdata;
        if (mem_rd) begin
            busy <= 1'b1;
            a <= mem_addr;
            n <= slow;
        end else if (busy && n != 2'h0) n <= n - 2'h1;
        else if (busy) begin
            busy <= 1'b0;
            mem_rvalid <= 1'b1;
            mem_rdata <= mem[a[12:0]];
        end
    end
endmodule

// ===== logger_memory_function_commands_bench.sv
`timescale 1ns/100ps
module logger_memory_function_commands_bench;
    import lgm_pkg::*;
    logic core_clk = 0, rst = 1, rx_valid = 0, rx_partial = 0, bus_reset = 0, tx_ready = 0;
    logic minute_tick = 0, sample_in_progress = 0, mission_enable_low = 1;
    logic [7:0] rx_data = 8'h00;
    logic [15:0] start_delay = 16'h0000;
    logic [1:0] slow = 2'h0;
    logic [7:0] tx_data, mem_rdata, mem_wdata;
    logic [15:0] mem_addr, crc;
    logic tx_valid, mem_rd, mem_we, mem_rvalid, copy_accepted_flag, clear_enable_bit;
    logic memory_cleared_bit, mission_in_progress, clear_active, convert_req;
    logic timestamp_capture, logging_active;
    int failures = 0, n_checks = 0;
    lgm_cmd_top #(.CLEAR_CYCLES(20)) uut (.*);
    lgm_mem_model mem_i (.*);
    always #20 core_clk = ~core_clk;
    // ****************************************
    // shared tasks
    // ****************************************
    task automatic end_sim;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input string w, input logic [15:0] seen, input logic [15:0] e);
        n_checks++;
        if (seen !== e) begin
            failures++;
            $display("unexpected %s expected %h seen %h", w, e, seen);
        end
    endtask
    // reflected crc, cleared then fed lsb first
    function automatic logic [15:0] upd(input logic [15:0] c, input logic [7:0] b);
        c ^= {8'h00, b};
        for (int i = 0; i < 8; i++) c = c[0] ? (c >> 1) ^ CRC_POLY : c >> 1;
        return c;
    endfunction
    task automatic put(input logic [7:0] b);
        @(negedge core_clk);
        rx_data = b;
        rx_valid = 1'b1;
        crc = upd(crc, b);
        @(negedge core_clk);
        rx_valid = 1'b0;
    endtask
    task automatic ex(input string w, input logic [7:0] e);
        @(negedge core_clk);
        repeat (5000) if (tx_valid !== 1'b1) @(negedge core_clk);
        chk("reply", {15'h0000, tx_valid}, 16'h0001);
        chk(w, {8'h00, tx_data}, {8'h00, e});
        crc = upd(crc, tx_data);
        tx_ready = 1'b1;
        @(negedge core_clk);
        tx_ready = 1'b0;
    endtask
    task automatic ex_crc;
        logic [15:0] c;
        c = ~crc;
        ex("crc low", c[7:0]);
        ex("crc high", c[15:8]);
    endtask
    task automatic brst;
        @(negedge core_clk);
        bus_reset = 1'b1;
        @(negedge core_clk);
        bus_reset = 1'b0;
        repeat (3) @(negedge core_clk);
        crc = CRC_INIT;
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    task automatic s_scratch;
        brst;
        put(CMD_WR_SP);
        put(8'h3C);
        put(8'h01);
        for (int i = 0; i < 4; i++) put(8'hD0 + 8'(i));
        brst;
        put(CMD_RD_SP);
        ex("target low", 8'h3C);
        ex("target high", 8'h01);
        ex("status", 8'h1F);
        for (int i = 0; i < 4; i++) ex("scratch data", 8'hD0 + 8'(i));
        ex_crc;
        ex("ones", ONES_BYTE);
    endtask
    task automatic s_copy;
        brst;
        put(CMD_COPY);
        put(8'h3C);
        put(8'h01);
        put(8'h1F);
        // reset pulse inside the copy must not cut it short
        brst;
        ex("alternating", ALT_PATTERN);
        ex("alternating", ALT_PATTERN);
        chk("copy flag", {15'h0000, copy_accepted_flag}, 16'h0001);
        brst;
        put(CMD_RD_SP);
        ex("target low", 8'h3C);
        ex("target high", 8'h01);
        ex("status", 8'h9F);
    endtask
    task automatic s_read;
        brst;
        slow = 2'h2;
        sample_in_progress = 1'b1;
        put(CMD_RD_MEM);
        put(8'h3B);
        put(8'h01);
        repeat (20) @(negedge core_clk);
        chk("held read", {15'h0000, tx_valid}, 16'h0000);
        sample_in_progress = 1'b0;
        ex("memory", 8'h3B);
        for (int i = 0; i < 4; i++) ex("copied", 8'hD0 + 8'(i));
        ex("memory", 8'h40);
        brst;
        put(CMD_RD_MEM);
        put(8'hFF);
        put(8'h17);
        ex("last byte", 8'hFF);
        ex("past end", ZERO_BYTE);
        ex("past end", ZERO_BYTE);
        brst;
        slow = 2'h0;
        put(CMD_RD_CRC);
        put(8'hFE);
        put(8'h01);
        // leave the buffer unread so it fills up
        repeat (100) @(negedge core_clk);
        ex("page data", 8'hFE);
        ex("page data", 8'hFF);
        ex_crc;
        crc = CRC_INIT;
        for (int i = 0; i < 32; i++) ex("next page", 8'(i));
        ex_crc;
    endtask
    task automatic wcopy(input logic [15:0] a, input logic [7:0] d);
        brst;
        put(CMD_WR_SP);
        put(a[7:0]);
        put(a[15:8]);
        put(d);
        brst;
        put(CMD_COPY);
        put(a[7:0]);
        put(a[15:8]);
        put({3'b000, a[4:0]});
        ex("alternating", ALT_PATTERN);
    endtask
    task automatic s_mission;
        brst;
        mission_enable_low = 1'b0;
        start_delay = 16'h0001;
        put(CMD_CONVERT);
        chk("convert", {15'h0000, convert_req}, 16'h0001);
        wcopy(CONTROL_ADDR, 8'h40);
        chk("clear enable", {15'h0000, clear_enable_bit}, 16'h0001);
        brst;
        // the oscillator counts as long settled here
        put(CMD_CLEAR);
        brst;
        chk("clearing", {15'h0000, clear_active}, 16'h0001);
        repeat (20) @(negedge core_clk);
        chk("cleared", {14'h0000, memory_cleared_bit, clear_enable_bit}, 16'h0002);
        brst;
        put(CMD_CLEAR);
        chk("clear refused", {15'h0000, clear_active}, 16'h0000);
        wcopy(SAMPLE_RATE_ADDR, 8'h01);
        chk("mission start", {14'h0000, mission_in_progress, memory_cleared_bit}, 16'h0002);
        for (int i = 0; i < 2; i++) begin
            minute_tick = 1'b1;
            @(negedge core_clk);
            minute_tick = 1'b0;
            chk("timestamp", {15'h0000, timestamp_capture}, 16'(i));
            @(negedge core_clk);
        end
        chk("logging", {15'h0000, logging_active}, 16'h0001);
        brst;
        put(CMD_CONVERT);
        chk("convert in mission", {15'h0000, convert_req}, 16'h0000);
        wcopy(MISSION_REG_FIRST, ZERO_BYTE);
        chk("mission stop", {14'h0000, mission_in_progress, logging_active}, 16'h0000);
    endtask
    initial begin
        repeat (30000) @(posedge core_clk);
        failures++;
        end_sim;
    end
    initial begin
        crc = CRC_INIT;
        repeat (12) @(negedge core_clk);
        rst = 1'b0;
        s_scratch;
        s_copy;
        s_read;
        s_mission;
        end_sim;
    end
endmodule
